// ---- design/aic_pkg.sv ----
package aic_pkg;
    // input range codes of the configurable channels
    typedef enum logic [1:0] {
        AIC_BIP10V = 2'b00,
        AIC_UNI10V = 2'b01,
        AIC_MA0_20 = 2'b10,
        AIC_MA4_20 = 2'b11
    } aic_type_e;

    // converter code: full scale 0x7FFF = 10 V or 20 mA
    localparam logic signed [16:0] AIC_CODE_MAX = 17'sh07FFF;
    localparam logic signed [16:0] AIC_CODE_MIN = -17'sh07FFF;
    // low end of each range in converter codes (4 mA = 0x1999)
    localparam logic signed [17:0] AIC_LOW_BIP = -18'sh07FFF;
    localparam logic signed [17:0] AIC_LOW_ZERO = 18'sh00000;
    localparam logic signed [17:0] AIC_LOW_4MA = 18'sh01999;
    // reciprocal of the span, 10000 * 2^24 / span, result in 0.01 %
    localparam int AIC_SHIFT = 24;
    localparam logic signed [24:0] AIC_K_BIP = 25'sh027104E;
    localparam logic signed [24:0] AIC_K_FULL = 25'sh04E209C;
    localparam logic signed [24:0] AIC_K_LOOP = 25'sh061A862;
    // 0.45 mA as the first code at or above it
    localparam logic signed [15:0] AIC_BRK_THRESH = 16'sh02E2;
    // break substitute, 0.01 % units: default -100 %, limit +-300 %
    localparam logic signed [15:0] AIC_BRKVAL_RST = 16'shD8F0;
    localparam logic signed [31:0] AIC_BRKVAL_MAX = 32'sh00007530;
    localparam logic signed [31:0] AIC_BRKVAL_MIN = -32'sh00007530;

    // register byte offsets
    localparam logic [7:0] AIC_OFF_CFG = 8'h00;
    localparam logic [7:0] AIC_OFF_BV3 = 8'h04;
    localparam logic [7:0] AIC_OFF_BV4 = 8'h08;
    localparam logic [7:0] AIC_OFF_STAT = 8'h0C;
    localparam logic [7:0] AIC_OFF_ISTAT = 8'h10;
    localparam logic [7:0] AIC_OFF_IMASK = 8'h14;
    localparam logic [7:0] AIC_OFF_VAL1 = 8'h18;
    localparam logic [7:0] AIC_OFF_VAL6 = 8'h2C;

    // field positions
    localparam int AIC_CFG_BRKEN = 8;
    localparam int AIC_ST_FIT = 0;
    localparam int AIC_ST_BRK3 = 1;
    localparam int AIC_ST_BRK4 = 2;
    localparam int AIC_IRQ_BRK3 = 0;
    localparam int AIC_IRQ_BRK4 = 1;
    localparam int AIC_IRQ_FIT = 2;
    localparam int AIC_IRQ_W = 3;
endpackage

// ---- design/aic_scale.sv ----
`timescale 1ns/1ps
`default_nettype none
module aic_scale (
    input wire logic signed [16:0] code,
    input wire aic_pkg::aic_type_e rangeSel,
    output logic signed [31:0] pct
);
    import aic_pkg::*;

    logic signed [17:0] low;
    logic signed [24:0] k;
    logic signed [17:0] span;
    logic signed [42:0] prod;

    // low end and reciprocal span of the selected range
    always_comb begin
        case (rangeSel)
            AIC_BIP10V: begin
                low = AIC_LOW_BIP;
                k = AIC_K_BIP;
            end
            AIC_UNI10V, AIC_MA0_20: begin
                low = AIC_LOW_ZERO;
                k = AIC_K_FULL;
            end
            AIC_MA4_20: begin
                low = AIC_LOW_4MA;
                k = AIC_K_LOOP;
            end
            default: begin
                low = AIC_LOW_BIP;
                k = AIC_K_BIP;
            end
        endcase
    end

    // multiply by reciprocal, no divider needed
    assign span = 18'(code) - low;
    assign prod = 43'(span) * 43'(k);
    assign pct = 32'(prod >>> AIC_SHIFT);
endmodule
`default_nettype wire

// ---- design/aic_break.sv ----
`timescale 1ns/1ps
`default_nettype none
module aic_break (
    input wire logic signed [15:0] code,
    input wire aic_pkg::aic_type_e rangeSel,
    input wire logic brkEn,
    input wire logic signed [15:0] brkVal,
    input wire logic signed [31:0] scaled,
    output logic brk,
    output logic signed [31:0] value
);
    import aic_pkg::*;

    // only a live loop below 0.45 mA counts as broken
    assign brk = brkEn && (rangeSel == AIC_MA4_20)
        && (code < AIC_BRK_THRESH);
    assign value = brk ? 32'(brkVal) : scaled;
endmodule
`default_nettype wire

// ---- design/aic_analog_input.sv ----
`timescale 1ns/1ps
`default_nettype none
module aic_analog_input (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic adcValid,
    input wire logic signed [15:0] adcCh1,
    input wire logic signed [15:0] adcCh2,
    input wire logic signed [15:0] adcCh3,
    input wire logic signed [15:0] adcCh4,
    input wire logic signed [15:0] adcCh6,
    input wire logic optFitted,
    output logic signed [31:0] value1,
    output logic signed [31:0] value2,
    output logic signed [31:0] value3,
    output logic signed [31:0] value4,
    output logic signed [31:0] value5,
    output logic signed [31:0] value6,
    output logic valueValid,
    output logic breakCh3,
    output logic breakCh4,
    output logic optPresent,
    output logic irq
);
    import aic_pkg::*;

    // range code update, current codes refused where not allowed
    function automatic aic_type_e typeNext(
        input aic_type_e cur,
        input logic [1:0] wcode,
        input logic we,
        input logic allowCurrent
    );
        typeNext = cur;
        if (we && (allowCurrent || !wcode[1])) begin
            typeNext = aic_type_e'(wcode);
        end
    endfunction

    // substitute value is limited rather than rejected
    function automatic logic signed [15:0] clampBrk(
        input logic signed [31:0] v
    );
        if (v > AIC_BRKVAL_MAX) begin
            clampBrk = 16'(AIC_BRKVAL_MAX);
        end else if (v < AIC_BRKVAL_MIN) begin
            clampBrk = 16'(AIC_BRKVAL_MIN);
        end else begin
            clampBrk = 16'(v);
        end
    endfunction

    aic_type_e rangeSel [4];
    aic_type_e nextRange [4];
    logic brkEn [2];
    logic next_brkEn [2];
    logic signed [15:0] brkVal [2];
    logic signed [15:0] next_brkVal [2];
    logic [AIC_IRQ_W-1:0] irqStat;
    logic [AIC_IRQ_W-1:0] irqMask;
    logic [AIC_IRQ_W-1:0] irqSet;
    logic [AIC_IRQ_W-1:0] irqClr;
    logic fittedNow;
    logic signed [31:0] value [6];
    logic signed [31:0] nextValue [6];
    logic signed [31:0] scaled [6];
    logic signed [16:0] codeIn [6];
    aic_type_e chType [6];
    logic signed [15:0] loopCode [2];
    logic brkNow [2];
    logic signed [31:0] brkOut [2];
    logic [31:0] rdMux;

    // bus phases and address decode
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wrEn = access & pwrite;
    wire hitCfg = paddr == AIC_OFF_CFG;
    wire hitBv3 = paddr == AIC_OFF_BV3;
    wire hitBv4 = paddr == AIC_OFF_BV4;
    wire hitStat = paddr == AIC_OFF_STAT;
    wire hitIstat = paddr == AIC_OFF_ISTAT;
    wire hitImask = paddr == AIC_OFF_IMASK;
    wire hitVal = (paddr >= AIC_OFF_VAL1) && (paddr <= AIC_OFF_VAL6)
        && (paddr[1:0] == 2'h0);
    wire mapped = hitCfg | hitBv3 | hitBv4 | hitStat | hitIstat
        | hitImask | hitVal;
    wire [2:0] valIdx = 3'((paddr - AIC_OFF_VAL1) >> 2);

    // zero wait states; unmapped or misaligned answers with an error
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // write strobes per register and lane
    wire wrTypes = wrEn & hitCfg & pstrb[0];
    wire wrEnables = wrEn & hitCfg & pstrb[1];
    wire wrBv3 = wrEn & hitBv3 & (&pstrb[1:0]);
    wire wrBv4 = wrEn & hitBv4 & (&pstrb[1:0]);
    wire wrIstat = wrEn & hitIstat & pstrb[0];
    wire wrImask = wrEn & hitImask & pstrb[0];

    // next range codes, two bits per channel in the low byte
    assign nextRange[0] = typeNext(rangeSel[0], pwdata[1:0], wrTypes, 1'b0);
    assign nextRange[1] = typeNext(rangeSel[1], pwdata[3:2], wrTypes, 1'b0);
    assign nextRange[2] = typeNext(rangeSel[2], pwdata[5:4], wrTypes, 1'b1);
    assign nextRange[3] = typeNext(rangeSel[3], pwdata[7:6], wrTypes, 1'b1);

    // enable is dropped as soon as the range cannot detect a break
    assign next_brkEn[0] = (wrEnables ? pwdata[AIC_CFG_BRKEN] : brkEn[0])
        & (nextRange[2] == AIC_MA4_20);
    assign next_brkEn[1] = (wrEnables ? pwdata[AIC_CFG_BRKEN+1] : brkEn[1])
        & (nextRange[3] == AIC_MA4_20);
    assign next_brkVal[0] = wrBv3 ? clampBrk(pwdata) : brkVal[0];
    assign next_brkVal[1] = wrBv4 ? clampBrk(pwdata) : brkVal[1];

    // configuration registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                rangeSel[i] <= AIC_BIP10V;
            end
            brkEn[0] <= 1'b0;
            brkEn[1] <= 1'b0;
            brkVal[0] <= AIC_BRKVAL_RST;
            brkVal[1] <= AIC_BRKVAL_RST;
        end else begin
            rangeSel <= nextRange;
            brkEn <= next_brkEn;
            brkVal <= next_brkVal;
        end
    end

    // channel five difference, saturated to the bipolar code span
    wire signed [17:0] diffRaw = 18'(adcCh1) - 18'(adcCh2);
    wire signed [16:0] diffCode = (diffRaw > 18'(AIC_CODE_MAX)) ? AIC_CODE_MAX
        : (diffRaw < 18'(AIC_CODE_MIN)) ? AIC_CODE_MIN
        : 17'(diffRaw);

    // per-channel code and range feeding the scalers
    assign codeIn[0] = 17'(adcCh1);
    assign codeIn[1] = 17'(adcCh2);
    assign codeIn[2] = 17'(adcCh3);
    assign codeIn[3] = 17'(adcCh4);
    assign codeIn[4] = diffCode;
    assign codeIn[5] = 17'(adcCh6);
    assign chType[0] = rangeSel[0];
    assign chType[1] = rangeSel[1];
    assign chType[2] = rangeSel[2];
    assign chType[3] = rangeSel[3];
    assign chType[4] = AIC_BIP10V;
    assign chType[5] = AIC_BIP10V;
    assign loopCode[0] = adcCh3;
    assign loopCode[1] = adcCh4;

    // six scalers; the arithmetic is small enough to duplicate
    for (genvar g = 0; g < 6; g++) begin : gScale
        aic_scale uScale (
            .code(codeIn[g]),
            .rangeSel(chType[g]),
            .pct(scaled[g])
        );
    end

    // break handling exists on the two loop-capable channels only
    for (genvar b = 0; b < 2; b++) begin : gBreak
        aic_break uBreak (
            .code(loopCode[b]),
            .rangeSel(rangeSel[b+2]),
            .brkEn(brkEn[b]),
            .brkVal(brkVal[b]),
            .scaled(scaled[b+2]),
            .brk(brkNow[b]),
            .value(brkOut[b])
        );
    end

    // readings chosen for the next sample
    assign nextValue[0] = scaled[0];
    assign nextValue[1] = scaled[1];
    assign nextValue[2] = brkOut[0];
    assign nextValue[3] = brkOut[1];
    assign nextValue[4] = scaled[4];
    assign nextValue[5] = optFitted ? scaled[5] : 32'sh00000000;

    // readings refresh on each converter sample
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < 6; i++) begin
                value[i] <= 32'sh00000000;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (adcValid) begin
                    value[i] <= nextValue[i];
                end
            end
            // channel six clears at once when the board goes, not at the next sample
            if (adcValid || !optFitted) begin
                value[5] <= nextValue[5];
            end
        end
    end

    // break flags, presence flag and sample strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            breakCh3 <= 1'b0;
            breakCh4 <= 1'b0;
            fittedNow <= 1'b0;
            valueValid <= 1'b0;
        end else begin
            if (adcValid) begin
                breakCh3 <= brkNow[0];
                breakCh4 <= brkNow[1];
            end
            fittedNow <= optFitted;
            valueValid <= adcValid;
        end
    end

    assign value1 = value[0];
    assign value2 = value[1];
    assign value3 = value[2];
    assign value4 = value[3];
    assign value5 = value[4];
    assign value6 = value[5];
    assign optPresent = fittedNow;

    // interrupt events: new break on either loop, board presence change
    assign irqSet[AIC_IRQ_BRK3] = adcValid & brkNow[0] & ~breakCh3;
    assign irqSet[AIC_IRQ_BRK4] = adcValid & brkNow[1] & ~breakCh4;
    assign irqSet[AIC_IRQ_FIT] = optFitted ^ fittedNow;
    assign irqClr = wrIstat ? pwdata[AIC_IRQ_W-1:0] : '0;

    // sticky status; a set in the clear cycle is kept
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irqStat <= '0;
            irqMask <= '0;
        end else begin
            irqStat <= (irqStat & ~irqClr) | irqSet;
            if (wrImask) begin
                irqMask <= pwdata[AIC_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irqStat & irqMask);

    // read data selection
    always_comb begin
        rdMux = 32'h00000000;
        if (hitCfg) begin
            rdMux[1:0] = rangeSel[0];
            rdMux[3:2] = rangeSel[1];
            rdMux[5:4] = rangeSel[2];
            rdMux[7:6] = rangeSel[3];
            rdMux[AIC_CFG_BRKEN] = brkEn[0];
            rdMux[AIC_CFG_BRKEN+1] = brkEn[1];
        end else if (hitBv3) begin
            rdMux[15:0] = brkVal[0];
        end else if (hitBv4) begin
            rdMux[15:0] = brkVal[1];
        end else if (hitStat) begin
            rdMux[AIC_ST_FIT] = fittedNow;
            rdMux[AIC_ST_BRK3] = breakCh3;
            rdMux[AIC_ST_BRK4] = breakCh4;
        end else if (hitIstat) begin
            rdMux[AIC_IRQ_W-1:0] = irqStat;
        end else if (hitImask) begin
            rdMux[AIC_IRQ_W-1:0] = irqMask;
        end else if (hitVal) begin
            rdMux = value[valIdx];
        end
    end

    // read data captured in setup so prdata comes from a flip-flop
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata <= rdMux;
        end
    end
endmodule
`default_nettype wire

// ---- dv/aic_adc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module aic_adc_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic go,
    input wire logic [2:0] gap,
    input wire logic signed [15:0] c1, c2, c3, c4, c6,
    output logic adcValid,
    output logic signed [15:0] adcCh1, adcCh2, adcCh3, adcCh4, adcCh6
);
    logic [79:0] held;
    logic [2:0] left;
    logic busy;
    // latch a request, strobe after a chosen delay so slow converters are seen too
    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy <= 1'b0;
            adcValid <= 1'b0;
        end else if (go) begin
            held <= {c1, c2, c3, c4, c6};
            left <= gap;
            busy <= 1'b1;
            adcValid <= 1'b0;
        end else begin
            adcValid <= busy && left == 3'h0;
            busy <= busy && left != 3'h0;
            left <= left - 3'h1;
        end
    end
    // codes are only good with the strobe; garbage otherwise
    assign {adcCh1, adcCh2, adcCh3, adcCh4, adcCh6} = adcValid ? held : ~held;
endmodule
`default_nettype wire

// ---- dv/aic_analog_input_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module aic_analog_input_asserts
    import aic_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic adcValid,
    input wire logic signed [15:0] adcCh1,
    input wire logic signed [15:0] adcCh2,
    input wire logic signed [15:0] adcCh3,
    input wire logic signed [15:0] adcCh6,
    input wire logic optFitted,
    input wire logic signed [31:0] value3,
    input wire logic signed [31:0] value5,
    input wire logic signed [31:0] value6,
    input wire logic valueValid,
    input wire logic breakCh3,
    input wire logic optPresent
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_sample_answer: assert property (adcValid |=> valueValid)
        else $error("no update after sample");
    a_no_spare_pulse: assert property (!adcValid |=> !valueValid)
        else $error("update without sample");
    a_absent_zero: assert property (!optFitted |=> value6 == 32'sh0)
        else $error("channel six not zero without board");
    a_flag_follows: assert property (nrst |=> optPresent == $past(optFitted))
        else $error("presence flag wrong");
    a_above_thresh: assert property (adcValid && adcCh3 >= AIC_BRK_THRESH |=> !breakCh3)
        else $error("break above threshold");
    a_subst_bound: assert property (breakCh3 |-> value3 >= -32'sh7530 && value3 <= 32'sh7530)
        else $error("substitute out of limits");
    a_equal_diff: assert property (adcValid && adcCh1 == adcCh2 |=> value5 == 32'sh1387)
        else $error("equal inputs not mid scale");
    a_six_low: assert property (adcValid && optFitted && adcCh6 == 16'sh8001 |=> value6 == 32'sh0)
        else $error("channel six low end not zero");
endmodule
bind aic_analog_input aic_analog_input_asserts chk (.*);
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module testbench;
    import aic_pkg::*;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, optFitted = 1, go = 0, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, seed = 32'h00009FEF;
    logic [3:0] pstrb = 4'hF, lanes = 4'hF;
    logic [2:0] gap = 0;
    logic signed [15:0] c1 = 0, c2 = 0, c3 = 0, c4 = 0, c6 = 0, adcCh1, adcCh2, adcCh3, adcCh4, adcCh6;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, adcValid, valueValid, breakCh3, breakCh4, optPresent, irq;
    wire logic signed [31:0] value1, value2, value3, value4, value5, value6;
    int n_errors = 0, tests_run = 0, cyc = 0;
    aic_analog_input uut (.*);
    aic_adc_model adc (.*);
    always #5 clk = ~clk;
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            results();
        end
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // converter codes; the one code below negative full scale is kept out
    function logic signed [15:0] rc();
        logic [15:0] r;
        r = 16'(rnd());
        return r == 16'h8000 ? 16'sh8001 : r;
    endfunction
    function logic signed [31:0] pct(input logic signed [16:0] c, input logic [1:0] r);
        logic signed [63:0] p;
        p = (64'(c) - 64'(r == 0 ? AIC_LOW_BIP : r == 3 ? AIC_LOW_4MA : AIC_LOW_ZERO))
            * 64'(r == 0 ? AIC_K_BIP : r == 3 ? AIC_K_LOOP : AIC_K_FULL);
        return 32'(p >>> AIC_SHIFT);
    endfunction
    function logic signed [16:0] sat(input logic signed [16:0] a, input logic signed [16:0] b);
        logic signed [16:0] d;
        d = a - b;
        return d > AIC_CODE_MAX ? AIC_CODE_MAX : d < AIC_CODE_MIN ? AIC_CODE_MIN : d;
    endfunction
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= lanes;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task samp(input logic signed [15:0] a1, a2, a3, a4, a6);
        @(posedge clk);
        {c1, c2, c3, c4, c6} <= {a1, a2, a3, a4, a6};
        gap <= 3'(rnd());
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 14 && valueValid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        `CHK(valueValid, 1'b1)
    endtask
    task results();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        apb(0, AIC_OFF_CFG, 0); `CHK(rd, 32'h0)
        apb(0, AIC_OFF_BV3, 0); `CHK(rd, 32'h0000D8F0)
        apb(0, AIC_OFF_BV4, 0); `CHK(rd, 32'h0000D8F0)
        apb(0, AIC_OFF_IMASK, 0); `CHK(rd, 32'h0)
        apb(0, 8'h30, 0); `CHK({err, rd}, 33'h100000000)
        apb(1, AIC_OFF_ISTAT, 32'h7);
        // current codes on ch1/ch2 are refused, ch4 enable dropped
        apb(1, AIC_OFF_CFG, 32'h37E);
        apb(0, AIC_OFF_CFG, 0); `CHK({err, rd}, {1'b0, 32'h170})
        // every range code with random codes, breaks disabled
        for (int r = 0; r < 4; r++) begin
            apb(1, AIC_OFF_CFG, 32'(r * 8'h50) | 32'(r & 1) * 5);
            repeat (6) begin
                samp(rc(), rc(), rc(), rc(), rc());
                `CHK(value1, pct(c1, 2'(r & 1)))
                `CHK(value2, pct(c2, 2'(r & 1)))
                `CHK(value3, pct(c3, 2'(r)))
                `CHK(value4, pct(c4, 2'(r)))
                `CHK(value5, pct(sat(c1, c2), 0))
                `CHK(value6, pct(c6, 0))
            end
        end
        // loop breaks either side of the threshold, clamped substitute
        apb(1, AIC_OFF_CFG, 32'h3F0);
        apb(1, AIC_OFF_BV3, 32'h00009C40);
        apb(0, AIC_OFF_BV3, 0); `CHK(rd, 32'h00007530)
        apb(1, AIC_OFF_BV4, 32'hFFFFEC78);
        // a low-lane-only write cannot touch the 16-bit substitute
        lanes = 4'h1;
        apb(1, AIC_OFF_BV4, 32'h00000000);
        lanes = 4'hF;
        apb(0, AIC_OFF_BV4, 0); `CHK(rd, 32'h0000EC78)
        apb(1, AIC_OFF_IMASK, 32'h1);
        samp(0, 0, 16'sh02E1, 16'sh02E2, 16'sh8001);
        `CHK({breakCh3, breakCh4, value3}, {2'b10, 32'sh7530})
        `CHK(value4, pct(16'sh02E2, 3))
        `CHK(irq, 1'b1)
        apb(1, AIC_OFF_IMASK, 32'h2); `CHK(irq, 1'b0)
        apb(1, AIC_OFF_IMASK, 32'h1); `CHK(irq, 1'b1)
        apb(1, AIC_OFF_ISTAT, 32'h1); `CHK(irq, 1'b0)
        samp(0, 0, 16'sh02E1, 16'sh0000, 0);
        `CHK({breakCh3, breakCh4, value4}, {2'b11, 32'hFFFFEC78})
        apb(0, AIC_OFF_ISTAT, 0); `CHK(rd, 32'h2)
        // leaving the loop range drops the enable and the detection
        apb(1, AIC_OFF_CFG, 32'h3E0);
        apb(0, AIC_OFF_CFG, 0); `CHK(rd, 32'h2E0)
        samp(0, 0, 0, 0, 0);
        `CHK({breakCh3, value3}, {1'b0, 32'sh0})
        // option board pulled
        @(posedge clk);
        optFitted <= 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK({optPresent, value6}, 33'h0)
        samp(0, 0, 0, 0, 16'sh7FFF);
        `CHK(value6, 32'sh0)
        apb(0, AIC_OFF_STAT, 0); `CHK(rd, 32'h4)
        apb(0, AIC_OFF_ISTAT, 0); `CHK(rd[2], 1'b1)
        results();
    end
endmodule
`default_nettype wire
